// ---- eplat_top.sv ----
// External pin interrupt latch: pin synchroniser, request latch, status
// and control registers, event interrupt and the CPU-facing request.
// Assumes the pin is asynchronous, vector fetch and break come from the
// CPU on the same clock, and the register master never overlaps strobes.
`timescale 1ns/1ps

module eplat_top
  import eplat_pkg::*;
(
  // Clock and reset.
  input  wire logic              CLK,
  input  wire logic              RST,
  // External interrupt pin, active low.
  input  wire logic              IRQ_PIN_N,
  // CPU side.
  input  wire logic              VEC_FETCH,
  input  wire logic              COND_CODE_I_MASK,
  input  wire logic              BREAK_STATE,
  output logic                   IRQ_REQ,
  output logic                   PIN_LEVEL,
  output logic [15:0]            VEC_ADDR_HI,
  output logic [15:0]            VEC_ADDR_LO,
  // Register port.
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic [DATA_W-1:0]      RDATA,
  // Event interrupt.
  output logic                   INT_OUT
);

  // Reject a data width that cannot hold the status and control fields.
  if (DATA_W < 4) begin : g_width_check
    $error("eplat_top: register width too small for the fields");
  end

  eplat_state_t state_q; // Registered state.
  eplat_state_t state_d; // Next state.

  logic fall;      // Falling edge on the filtered pin.
  logic pin_low;   // Filtered pin is low.
  logic sc_wr;     // Write to status and control.
  logic sw_ack;    // Software acknowledge that may take effect.
  logic any_ack;   // Any acknowledge this cycle.

  // Decode of strobes and edge detection on the filtered pin.
  always_comb begin
    // The edge is taken only from the agreed filtered level, never from a
    // raw synchroniser stage, so a metastable sample cannot fake an edge.
    fall    = state_q.pin & ~state_d.pin;
    pin_low = ~state_q.pin;
    sc_wr   = WR && (ADDR == SC_OFS);
    // A break without the clear enable protects the latch from software.
    sw_ack  = sc_wr && WDATA[ACK_BIT] && (!BREAK_STATE || state_q.break_clear_enable);
    // The vector fetch only ever acknowledges this latch.
    any_ack = VEC_FETCH || sw_ack;
  end

  // Next-state logic for the whole block.
  always_comb begin
    state_d = state_q;

    // Three-stage synchroniser; the level moves once stages two and three agree.
    state_d.sync1 = IRQ_PIN_N;
    state_d.sync2 = state_q.sync1;
    state_d.sync3 = state_q.sync2;
    if (state_q.sync2 == state_q.sync3) begin
      state_d.pin = state_q.sync3;
    end

    // Request latch. A fresh edge always wins over a clear in the same cycle.
    if (!state_q.mode) begin
      // Edge only: any acknowledge clears at once, whatever the pin level, unless a fresh edge comes in the same cycle.
      if (fall) begin
        state_d.latch = 1'b1;
      end else if (any_ack) begin
        state_d.latch = 1'b0;
      end
      state_d.ackd = 1'b0;
    end else begin
      // Edge and level: a low pin keeps the request alive after an ack.
      if (fall || pin_low) begin
        state_d.latch = 1'b1;
      end else if (any_ack || state_q.ackd) begin
        state_d.latch = 1'b0;
      end
      // Remember an acknowledge until the pin returns high.
      state_d.ackd = state_d.latch && (state_q.ackd || any_ack);
    end

    // Control bits of the status and control register.
    if (sc_wr) begin
      state_d.mode  = WDATA[MODE_BIT];
      state_d.lmask = WDATA[MASK_BIT];
    end

    // Break flag control register.
    if (WR && (ADDR == BRK_OFS)) begin
      state_d.break_clear_enable = WDATA[BREAK_CLEAR_ENABLE_BIT];
    end

    // Event mask register.
    if (WR && (ADDR == MSK_OFS)) begin
      state_d.emsk = WDATA[EVT_W-1:0];
    end

    // Sticky events: write one to clear, and a new event beats the clear.
    if (WR && (ADDR == EVT_OFS)) begin
      state_d.evt = state_q.evt & ~WDATA[EVT_W-1:0];
    end
    if (fall) begin
      state_d.evt[EVT_FALL] = 1'b1;
    end
    if (VEC_FETCH) begin
      state_d.evt[EVT_SERVICE] = 1'b1;
    end

    // Read data stand for exactly one cycle after the read strobe.
    state_d.rdata = RD_RST;
    if (RD) begin
      case (ADDR)
        SC_OFS: begin
          // The pending flag ignores the local mask; ack reads as zero.
          state_d.rdata[PEND_BIT] = state_q.latch;
          state_d.rdata[ACK_BIT]  = 1'b0;
          state_d.rdata[MASK_BIT] = state_q.lmask;
          state_d.rdata[MODE_BIT] = state_q.mode;
        end
        EVT_OFS: begin
          state_d.rdata[EVT_W-1:0] = state_q.evt;
        end
        MSK_OFS: begin
          state_d.rdata[EVT_W-1:0] = state_q.emsk;
        end
        BRK_OFS: begin
          state_d.rdata[BREAK_CLEAR_ENABLE_BIT] = state_q.break_clear_enable;
        end
        default: begin
          // Unmapped addresses read as zero.
          state_d.rdata = RD_RST;
        end
      endcase
    end

    // The vector locations are fixed; they are held in flip-flops.
    state_d.vec_hi = VEC_HI_LOC;
    state_d.vec_lo = VEC_LO_LOC;
  end

  // State register with synchronous reset.
  always_ff @(posedge CLK) begin
    if (RST) begin
      // The chain keeps sampling through reset and the filtered level takes
      // the agreed level, idle high unless both stages hold low; a pin held
      // low through reset then shows no falling edge when reset ends.
      state_q.sync1  <= IRQ_PIN_N;
      state_q.sync2  <= state_q.sync1;
      state_q.sync3  <= state_q.sync2;
      state_q.pin    <= state_q.sync2 | state_q.sync3;
      state_q.latch  <= 1'b0;
      state_q.ackd   <= 1'b0;
      state_q.mode   <= MODE_RST;
      state_q.lmask  <= MASK_RST;
      state_q.break_clear_enable   <= BREAK_CLEAR_ENABLE_RST;
      state_q.evt    <= EVT_RST;
      state_q.emsk   <= EVT_RST;
      state_q.rdata  <= RD_RST;
      state_q.vec_hi <= VEC_HI_LOC;
      state_q.vec_lo <= VEC_LO_LOC;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs. The request is withheld by either the local or the global mask.
  // Software in level mode is expected to set the local mask in its handler
  // otherwise the still-low pin raises the request again at once.
  assign IRQ_REQ     = state_q.latch && !state_q.lmask && !COND_CODE_I_MASK;
  assign PIN_LEVEL   = state_q.pin;
  assign VEC_ADDR_HI = state_q.vec_hi;
  assign VEC_ADDR_LO = state_q.vec_lo;
  assign RDATA       = state_q.rdata;
  assign INT_OUT     = |(state_q.evt & state_q.emsk);

  // Checks on the behaviour above.

  // A fall is a high filtered level followed by a low one.
  sequence fall_seq;
    state_q.pin ##1 !state_q.pin;
  endsequence

  // A read of the status and control register.
  sequence sc_read_seq;
    RD && (ADDR == SC_OFS);
  endsequence

  // A software acknowledge or a vector fetch in the same cycle.
  sequence ack_seq;
    any_ack;
  endsequence

  // The last two synchroniser stages agree on one level.
  sequence agree_seq;
    state_q.sync2 == state_q.sync3;
  endsequence

  // A falling edge leaves the latch set.
  property fall_sets_p;
    @(posedge CLK) disable iff (RST)
      fall_seq |-> state_q.latch;
  endproperty
  fall_set_a: assert property (fall_sets_p)
    else $error("falling edge did not set the latch");

  // Pending flag mirrors the latch one cycle after the read.
  pend_flag_a: assert property (
    @(posedge CLK) disable iff (RST)
      sc_read_seq |=> (RDATA[PEND_BIT] == $past(state_q.latch)))
    else $error("pending flag does not match the latch");

  // Acknowledge bit always reads zero.
  ack_reads_zero_a: assert property (
    @(posedge CLK) disable iff (RST)
      sc_read_seq |=> !RDATA[ACK_BIT])
    else $error("acknowledge bit read as one");

  // Either mask withholds the request.
  mask_gate_a: assert property (
    @(posedge CLK) disable iff (RST)
      IRQ_REQ |-> (!state_q.lmask && !COND_CODE_I_MASK && state_q.latch))
    else $error("request presented while masked");

  // Edge mode acknowledge clears at once.
  edge_clear_a: assert property (
    @(posedge CLK) disable iff (RST)
      (!state_q.mode && state_q.latch && VEC_FETCH && !fall) |=> !state_q.latch)
    else $error("edge mode acknowledge did not clear");

  // Level mode keeps the request while the pin stays low.
  level_hold_a: assert property (
    @(posedge CLK) disable iff (RST)
      (state_q.mode && !state_q.pin) |=> state_q.latch)
    else $error("level request dropped with pin low");

  // Level mode clears once acknowledged and the pin is high.
  level_release_a: assert property (
    @(posedge CLK) disable iff (RST)
      (state_q.mode && state_q.ackd && state_q.pin && !fall && state_d.pin)
      |=> !state_q.latch)
    else $error("level request not released");

  // A protected break ignores a software acknowledge.
  break_protect_a: assert property (
    @(posedge CLK) disable iff (RST)
      (state_q.latch && BREAK_STATE && !state_q.break_clear_enable && !VEC_FETCH && !state_q.mode
       && sc_wr) |=> state_q.latch)
    else $error("acknowledge took effect in protected break");

  // Reset clears latch, mode and mask.
  reset_clear_a: assert property (
    @(posedge CLK)
      RST |=> (!state_q.latch && !state_q.mode && !state_q.lmask))
    else $error("reset left latch or control set");

  // The filtered level takes the third stage once two and three agree.
  pin_follow_a: assert property (
    @(posedge CLK) disable iff (RST)
      agree_seq |=> (state_q.pin == $past(state_q.sync3)))
    else $error("filtered pin did not follow agreeing stages");

  // A disagreement between stages two and three leaves the level alone.
  pin_hold_a: assert property (
    @(posedge CLK) disable iff (RST)
      (state_q.sync2 != state_q.sync3) |=> $stable(state_q.pin))
    else $error("filtered pin moved while stages disagreed");

  // The vector locations never move.
  vec_const_a: assert property (
    @(posedge CLK) disable iff (RST)
      (VEC_ADDR_HI == VEC_HI_LOC) && (VEC_ADDR_LO == VEC_LO_LOC))
    else $error("vector location output changed");

  // Edge mode software acknowledge clears the latch on the next edge.
  sw_ack_edge_a: assert property (
    @(posedge CLK) disable iff (RST)
      (!state_q.mode && state_q.latch && sw_ack && !fall) |=> !state_q.latch)
    else $error("software acknowledge did not clear in edge mode");

  // A break with the clear enable set lets software clear the latch.
  break_clear_a: assert property (
    @(posedge CLK) disable iff (RST)
      (BREAK_STATE && state_q.break_clear_enable && !state_q.mode && sc_wr && WDATA[ACK_BIT] && !fall)
      |=> !state_q.latch)
    else $error("acknowledge ignored although break clear is enabled");

  // A vector fetch touches no control bit, only this latch and the service event.
  fetch_only_a: assert property (
    @(posedge CLK) disable iff (RST)
      (VEC_FETCH && !WR) |=> ($stable(state_q.mode) && $stable(state_q.lmask)
      && $stable(state_q.break_clear_enable)))
    else $error("vector fetch disturbed a control bit");

  // A falling edge in the cycle of an acknowledge still sets the latch.
  edge_beats_ack_a: assert property (
    @(posedge CLK) disable iff (RST)
      (fall ##0 ack_seq) |=> state_q.latch)
    else $error("acknowledge swallowed a falling edge");

  // Reset leaves the outputs quiet.
  reset_out_a: assert property (
    @(posedge CLK)
      RST |=> (!IRQ_REQ && !INT_OUT && (RDATA == RD_RST)))
    else $error("outputs not quiet after reset");

  // An acknowledge while the pin is low is remembered in level mode.
  level_ack_mem_a: assert property (
    @(posedge CLK) disable iff (RST)
      ((state_q.mode && !state_q.pin) ##0 ack_seq) |=> (state_q.latch && state_q.ackd))
    else $error("level mode acknowledge not remembered");

  // A remembered acknowledge never outlives the latch.
  ackd_latch_a: assert property (
    @(posedge CLK) disable iff (RST)
      state_q.ackd |-> state_q.latch)
    else $error("acknowledge memory set without a latch");

  // An unmasked latched request is presented at once.
  req_present_a: assert property (
    @(posedge CLK) disable iff (RST)
      (state_q.latch && !state_q.lmask && !COND_CODE_I_MASK) |-> IRQ_REQ)
    else $error("unmasked request not presented");

  // The global mask blocks the request whatever the latch holds.
  global_mask_a: assert property (
    @(posedge CLK) disable iff (RST)
      COND_CODE_I_MASK |-> !IRQ_REQ)
    else $error("request presented under the global mask");

  // A falling edge is recorded as an event.
  evt_fall_a: assert property (
    @(posedge CLK) disable iff (RST)
      fall |=> state_q.evt[EVT_FALL])
    else $error("falling edge event not recorded");

  // A vector fetch is recorded as an event.
  evt_service_a: assert property (
    @(posedge CLK) disable iff (RST)
      VEC_FETCH |=> state_q.evt[EVT_SERVICE])
    else $error("vector fetch event not recorded");

  // Unused bits of the status and control register read as zero.
  sc_upper_zero_a: assert property (
    @(posedge CLK) disable iff (RST)
      sc_read_seq |=> (RDATA[DATA_W-1:PEND_BIT+1] == '0))
    else $error("unused status bits read as one");

  // The mask bit reads back as held.
  mask_read_a: assert property (
    @(posedge CLK) disable iff (RST)
      sc_read_seq |=> (RDATA[MASK_BIT] == $past(state_q.lmask)))
    else $error("mask bit read back wrong");

  // Edge mode: a steady low pin alone never sets a clear latch.
  edge_no_level_a: assert property (
    @(posedge CLK) disable iff (RST)
      (!state_q.mode && !state_q.latch && !fall) |=> !state_q.latch)
    else $error("edge mode latch set without an edge");

  // The mode bit reads back as held.
  mode_read_a: assert property (
    @(posedge CLK) disable iff (RST)
      sc_read_seq |=> (RDATA[MODE_BIT] == $past(state_q.mode)))
    else $error("mode bit read back wrong");

  // Without a read strobe the read data return to zero.
  rdata_idle_a: assert property (
    @(posedge CLK) disable iff (RST)
      !RD |=> (RDATA == RD_RST))
    else $error("read data stood without a read");

  // The break clear enable reads back as held.
  break_clear_enable_read_a: assert property (
    @(posedge CLK) disable iff (RST)
      (RD && (ADDR == BRK_OFS)) |=> (RDATA[BREAK_CLEAR_ENABLE_BIT] == $past(state_q.break_clear_enable)))
    else $error("break clear enable read back wrong");

endmodule : eplat_top

// ---- eplat_pkg.sv ----
// Constants, register map and state layout of the external pin interrupt latch.
// Assumes a single system clock and a plain one-cycle register port.
package eplat_pkg;

  // Register bus geometry.
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;

  // Register offsets on the plain register port.
  localparam logic [ADDR_W-1:0] SC_OFS   = 8'h00; // Status and control.
  localparam logic [ADDR_W-1:0] EVT_OFS  = 8'h01; // Sticky event status.
  localparam logic [ADDR_W-1:0] MSK_OFS  = 8'h02; // Event interrupt mask.
  localparam logic [ADDR_W-1:0] BRK_OFS  = 8'h03; // Break flag control.

  // Field positions inside the status and control register.
  localparam int unsigned MODE_BIT = 0; // Edge/level select.
  localparam int unsigned MASK_BIT = 1; // Local request mask.
  localparam int unsigned ACK_BIT  = 2; // Write-only acknowledge.
  localparam int unsigned PEND_BIT = 3; // Read-only pending flag.

  // Field position of the break clear enable.
  localparam int unsigned BREAK_CLEAR_ENABLE_BIT = 0;

  // Sticky event bits.
  localparam int unsigned EVT_W       = 2;
  localparam int unsigned EVT_FALL    = 0; // A falling edge was seen.
  localparam int unsigned EVT_SERVICE = 1; // A vector fetch was taken.

  // Values after reset.
  localparam logic              MODE_RST = 1'b0;
  localparam logic              MASK_RST = 1'b0;
  localparam logic              BREAK_CLEAR_ENABLE_RST = 1'b0;
  localparam logic [EVT_W-1:0]  EVT_RST  = 2'h0;
  localparam logic [DATA_W-1:0] RD_RST   = 8'h00;

  // Vector locations of this interrupt, high byte then low byte.
  localparam logic [15:0] VEC_HI_LOC = 16'hfffa;
  localparam logic [15:0] VEC_LO_LOC = 16'hfffb;

  // Whole state of the block, registered as one word.
  typedef struct packed {
    logic              sync1;   // First synchroniser stage.
    logic              sync2;   // Second synchroniser stage.
    logic              sync3;   // Third synchroniser stage.
    logic              pin;     // Filtered pin level.
    logic              latch;   // Request latch.
    logic              ackd;    // Acknowledge seen, level mode.
    logic              mode;    // Edge/level select.
    logic              lmask;   // Local request mask.
    logic              break_clear_enable;    // Break clear enable.
    logic [EVT_W-1:0]  evt;     // Sticky events.
    logic [EVT_W-1:0]  emsk;    // Event mask.
    logic [DATA_W-1:0] rdata;   // Read data register.
    logic [15:0]       vec_hi;  // Vector high byte location.
    logic [15:0]       vec_lo;  // Vector low byte location.
  } eplat_state_t;

endpackage : eplat_pkg

// ---- eplat_src.sv ----
// Model of the outside source that drives the active-low interrupt pin.
// Assumes the pin has a pull-up, so a released pin reads high.
`timescale 1ns/1ps

module eplat_src (
  // Command from the bench.
  input  wire logic pull_low,
  // Interrupt pin, active low.
  output logic      pin_n
);
  // A released pin goes to the pull-up level, never to a stale low.
  assign pin_n = pull_low ? 1'b0 : 1'b1;
endmodule : eplat_src

// ---- test_external_pin_interrupt_latch.sv ----
// Self-checking bench of the external pin interrupt latch.
// Assumes the design package, the design and the pin source model.
`timescale 1ns/1ps

module test_external_pin_interrupt_latch;
  import eplat_pkg::*;

  logic        clk, rst, pull_low, pin_n, vfetch, gmask, brk, wr, rd;
  logic        irq_req, pin_level, int_out;
  logic [7:0]  addr, wdata, rdata;
  logic [15:0] vec_hi, vec_lo;
  int          mismatches, cmp_count, cycles;

  eplat_src src (.pull_low(pull_low), .pin_n(pin_n));

  eplat_top dut (
    .CLK(clk), .RST(rst), .IRQ_PIN_N(pin_n), .VEC_FETCH(vfetch),
    .COND_CODE_I_MASK(gmask), .BREAK_STATE(brk), .IRQ_REQ(irq_req),
    .PIN_LEVEL(pin_level), .VEC_ADDR_HI(vec_hi), .VEC_ADDR_LO(vec_lo),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .INT_OUT(int_out)
  );

  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  // A hang counts as a mismatch and ends the run.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One-cycle write; the register holds the value after the taking edge.
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wrr

  // One-cycle read; data stand only in the cycle after the strobe.
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, exp});
  endtask : rdc

  task automatic vf();
    @(posedge clk);
    vfetch <= 1'b1;
    @(posedge clk);
    vfetch <= 1'b0;
    #1;
  endtask : vf

  // Moves the pin and waits, bounded, for the filtered level to follow.
  task automatic pin_go(input logic lvl);
    int n;
    n = 0;
    @(posedge clk);
    pull_low <= ~lvl;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (pin_level !== lvl && n < 8);
  endtask : pin_go

  task automatic t_reset();
    rdc(SC_OFS, 8'h00);
    rdc(EVT_OFS, 8'h00);
    rdc(MSK_OFS, 8'h00);
    rdc(BRK_OFS, 8'h00);
    rdc(8'h07, 8'h00);
    chk(vec_hi, 16'hfffa);
    chk(vec_lo, 16'hfffb);
  endtask : t_reset

  task automatic t_edge();
    wrr(MSK_OFS, 8'h03);
    pin_go(1'b0);
    chk(16'(pin_level), 16'h0000);
    chk(16'(irq_req), 16'h0001);
    chk(16'(int_out), 16'h0001);
    rdc(SC_OFS, 8'h08);
    vf();
    chk(16'(irq_req), 16'h0000);
    rdc(EVT_OFS, 8'h03);
    wrr(EVT_OFS, 8'h03);
    chk(16'(int_out), 16'h0000);
    pin_go(1'b1);
    chk(16'(pin_level), 16'h0001);
  endtask : t_edge

  task automatic t_ack();
    pin_go(1'b0);
    wrr(SC_OFS, 8'h02);
    chk(16'(irq_req), 16'h0000);
    rdc(SC_OFS, 8'h0a);
    wrr(SC_OFS, 8'h00);
    gmask <= 1'b1;
    @(posedge clk);
    #1;
    chk(16'(irq_req), 16'h0000);
    gmask <= 1'b0;
    wrr(SC_OFS, 8'h04);
    chk(16'(irq_req), 16'h0000);
    rdc(SC_OFS, 8'h00);
    pin_go(1'b1);
    pin_go(1'b0);
    chk(16'(irq_req), 16'h0001);
    wrr(MSK_OFS, 8'h00);
    chk(16'(int_out), 16'h0000);
    wrr(EVT_OFS, 8'h03);
    wrr(SC_OFS, 8'h04);
    pin_go(1'b1);
  endtask : t_ack

  task automatic t_level();
    wrr(SC_OFS, 8'h01);
    pin_go(1'b0);
    chk(16'(irq_req), 16'h0001);
    wrr(SC_OFS, 8'h07);
    rdc(SC_OFS, 8'h0b);
    pin_go(1'b1);
    rdc(SC_OFS, 8'h03);
    wrr(SC_OFS, 8'h01);
    pin_go(1'b0);
    pin_go(1'b1);
    rdc(SC_OFS, 8'h09);
    vf();
    rdc(SC_OFS, 8'h01);
  endtask : t_level

  task automatic t_break();
    wrr(SC_OFS, 8'h00);
    brk <= 1'b1;
    pin_go(1'b0);
    wrr(SC_OFS, 8'h04);
    rdc(SC_OFS, 8'h08);
    wrr(BRK_OFS, 8'h01);
    rdc(BRK_OFS, 8'h01);
    wrr(SC_OFS, 8'h04);
    brk <= 1'b0;
    rdc(SC_OFS, 8'h00);
    wrr(BRK_OFS, 8'h00);
  endtask : t_break

  // Reset with the pin still low must drop the request and the mode.
  task automatic t_rst_mid();
    wrr(SC_OFS, 8'h01);
    rdc(SC_OFS, 8'h09);
    rst <= 1'b1;
    @(posedge clk);
    #1;
    chk(16'(irq_req), 16'h0000);
    rst <= 1'b0;
    rdc(SC_OFS, 8'h00);
    repeat (6) @(posedge clk);
    rdc(SC_OFS, 8'h00);
    chk(16'(irq_req), 16'h0000);
    pin_go(1'b1);
  endtask : t_rst_mid

  initial begin
    rst = 1'b1; pull_low = 1'b0; vfetch = 1'b0; gmask = 1'b0; brk = 1'b0;
    wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 8'h00;
    mismatches = 0; cmp_count = 0; cycles = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_edge();
    t_ack();
    t_level();
    t_break();
    t_rst_mid();
    end_sim();
  end
endmodule : test_external_pin_interrupt_latch
